// *** src/gpa_port.sv ***
// gpa_port.sv: eight pin io port with pull-ups behind an axi4-lite slave
// assumes: pins asynchronous, peripheral outputs on ref_clk_i
// How it works
// - eight bidirectional pins, each with a software switched pull-up
// - each pin direction comes from the decode of its latch, dir and function select bits
// - output latch gives both drive level and pull-up enable
// - pin input read returns sampled pin levels, not the latch
// - pins set for inverted input read back complemented
// - pin input read works whatever the pin direction
// - function selects a and b pick the output mode with latch, dir
// - pins 0 to 3 can carry the synchronous serial channel
// - pins 4 to 6 can carry the slave i2c interface
// - function a clear: open, pull-up, drive, slow, low, inverted open
// - pin level always goes to the sharing peripheral inputs
`timescale 1ns/1ps
`default_nettype none
`include "gpa_map.svh"

module gpa_port
  import gpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire gpa_pkg::gpa_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire gpa_pkg::gpa_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire gpa_pkg::gpa_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output gpa_pkg::gpa_data_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // pins
  input wire gpa_pkg::gpa_port_t pin_i,
  output gpa_pkg::gpa_port_t pin_o,
  output gpa_pkg::gpa_port_t pin_oe_o,
  output gpa_pkg::gpa_port_t pullup_en_o,
  output gpa_pkg::gpa_port_t slow_change_o,
  // shared peripherals
  input wire logic [3:0] synchronous_serial_channel_out_i,
  output logic [3:0] synchronous_serial_channel_in_o,
  input wire logic [2:0] slave_i2c_interface_out_i,
  output logic [2:0] slave_i2c_interface_in_o
);

  gpa_port_t port_output_latch_q;
  gpa_port_t port_direction_q;
  gpa_port_t port_function_select_a_q;
  gpa_port_t port_function_select_b_q;
  gpa_port_t pin_sync;
  gpa_port_t invert_q;
  gpa_port_t periph_out;
  gpa_port_t drive_d;
  gpa_port_t level_d;
  gpa_port_t pullup_d;
  gpa_port_t slow_d;
  gpa_port_t invert_d;
  gpa_port_t pin_q;
  gpa_port_t pin_oe_q;
  gpa_port_t pullup_q;
  gpa_port_t slow_q;
  logic [3:0] serial_in_q;
  logic [2:0] i2c_in_q;

  // write channel state
  gpa_wr_state_e wr_state_q;
  logic aw_have_q;
  logic w_have_q;
  gpa_addr_t wr_addr_q;
  gpa_data_t wr_data_q;
  logic [3:0] wr_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic b_done;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;

  // read channel state
  gpa_rd_state_e rd_state_q;
  logic arready_q;
  logic rvalid_q;
  gpa_data_t rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic r_done;

  // byte address of a register index
  function automatic gpa_addr_t reg_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // mapped addresses: 0 none, 1 latch, 2 input, 3 dir, 4 fsa, 5 fsb
  function automatic logic [2:0] decode(input gpa_addr_t addr);
    logic [2:0] sel;
    sel = 3'h0;
    case ({addr[`GPA_ADDR_W-1:2], 2'b00})
      reg_addr(`GPA_IDX_OUTPUT_LATCH): sel = 3'h1;
      reg_addr(`GPA_IDX_PIN_INPUT): sel = 3'h2;
      reg_addr(`GPA_IDX_DIRECTION): sel = 3'h3;
      reg_addr(`GPA_IDX_FUNC_SEL_A): sel = 3'h4;
      reg_addr(`GPA_IDX_FUNC_SEL_B): sel = 3'h5;
      default: sel = 3'h0;
    endcase
    return sel;
  endfunction

  // pin input sampling
  gpa_pin_sync u_sync
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  assign periph_out = {1'b0, slave_i2c_interface_out_i,
    synchronous_serial_channel_out_i};

  gpa_pin_ctrl u_ctrl
  (
    .latch_i(port_output_latch_q),
    .dir_i(port_direction_q),
    .fsa_i(port_function_select_a_q),
    .fsb_i(port_function_select_b_q),
    .periph_out_i(periph_out),
    .drive_o(drive_d),
    .level_o(level_d),
    .pullup_o(pullup_d),
    .slow_o(slow_d),
    .invert_o(invert_d)
  );

  // registered pin outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pin_q <= 8'h00;
      pin_oe_q <= 8'h00;
      pullup_q <= 8'h00;
      slow_q <= 8'h00;
      invert_q <= 8'h00;
    end
    else
    begin
      pin_q <= level_d;
      pin_oe_q <= drive_d;
      pullup_q <= pullup_d;
      slow_q <= slow_d;
      invert_q <= invert_d;
    end
  end

  // peripheral inputs take the pin level in every mode
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      serial_in_q <= 4'h0;
      i2c_in_q <= 3'h0;
    end
    else
    begin
      serial_in_q <= pin_sync[3:0];
      i2c_in_q <= pin_sync[6:4];
    end
  end

  // write channel
  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take = s_axi_wvalid & wready_q;
  assign wr_go = aw_have_q & w_have_q & (wr_state_q == GPA_WR_IDLE);
  assign b_done = bvalid_q & s_axi_bready;
  assign aw_have_d = (aw_have_q | aw_take) & ~wr_go;
  assign w_have_d = (w_have_q | w_take) & ~wr_go;
  assign bvalid_d = (bvalid_q & ~s_axi_bready) | wr_go;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= 4'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q <= ~w_have_d & ~bvalid_d;
      if (aw_take)
      begin
        wr_addr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wr_state_q <= GPA_WR_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= `GPA_RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        GPA_WR_IDLE:
        begin
          if (wr_go)
          begin
            wr_state_q <= GPA_WR_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= (decode(wr_addr_q) == 3'h0) ?
              `GPA_RESP_SLVERR : `GPA_RESP_OKAY;
          end
        end
        GPA_WR_RESP:
        begin
          if (b_done)
          begin
            wr_state_q <= GPA_WR_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default:
        begin
          wr_state_q <= GPA_WR_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // control registers, low byte lane only
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      port_output_latch_q <= `GPA_RST_OUTPUT_LATCH;
      port_direction_q <= `GPA_RST_DIRECTION;
      port_function_select_a_q <= `GPA_RST_FUNC_SEL_A;
      port_function_select_b_q <= `GPA_RST_FUNC_SEL_B;
    end
    else if (wr_go && wr_strb_q[0])
    begin
      case (decode(wr_addr_q))
        3'h1: port_output_latch_q <= wr_data_q[7:0];
        3'h3: port_direction_q <= wr_data_q[7:0];
        3'h4: port_function_select_a_q <= wr_data_q[7:0];
        3'h5: port_function_select_b_q <= wr_data_q[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // read channel
  assign ar_take = s_axi_arvalid & arready_q;
  assign r_done = rvalid_q & s_axi_rready;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_state_q <= GPA_RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `GPA_RESP_OKAY;
    end
    else
    begin
      case (rd_state_q)
        GPA_RD_IDLE:
        begin
          arready_q <= ~ar_take;
          if (ar_take)
          begin
            rd_state_q <= GPA_RD_RESP;
            rvalid_q <= 1'b1;
            rresp_q <= `GPA_RESP_OKAY;
            rdata_q <= '0;
            case (decode(s_axi_araddr))
              3'h1: rdata_q[7:0] <= port_output_latch_q;
              // pin levels in any direction
              3'h2: rdata_q[7:0] <= pin_sync ^ invert_q;
              3'h3: rdata_q[7:0] <= port_direction_q;
              3'h4: rdata_q[7:0] <= port_function_select_a_q;
              3'h5: rdata_q[7:0] <= port_function_select_b_q;
              default: rresp_q <= `GPA_RESP_SLVERR;
            endcase
          end
        end
        GPA_RD_RESP:
        begin
          if (r_done)
          begin
            rd_state_q <= GPA_RD_IDLE;
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
          end
        end
        default:
        begin
          rd_state_q <= GPA_RD_IDLE;
          rvalid_q <= 1'b0;
          arready_q <= 1'b0;
        end
      endcase
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_o = pin_q;
  assign pin_oe_o = pin_oe_q;
  assign pullup_en_o = pullup_q;
  assign slow_change_o = slow_q;
  assign synchronous_serial_channel_in_o = serial_in_q;
  assign slave_i2c_interface_in_o = i2c_in_q;

endmodule

`default_nettype wire

// *** shared/gpa_map.svh ***
// gpa_map.svh: register map, reset values and bus codes of the io port
// assumes: included by bare name from the package and design files
`ifndef GPA_MAP_SVH
`define GPA_MAP_SVH

// register indices as printed, byte address is four times the index
`define GPA_IDX_OUTPUT_LATCH 16'h7FC8
`define GPA_IDX_PIN_INPUT 16'h7FC9
`define GPA_IDX_DIRECTION 16'h7FCA
`define GPA_IDX_FUNC_SEL_A 16'h7FCB
`define GPA_IDX_FUNC_SEL_B 16'h7FFA

`define GPA_ADDR_W 18
`define GPA_DATA_W 32
`define GPA_PORT_W 8

// reset values
`define GPA_RST_OUTPUT_LATCH 8'h00
`define GPA_RST_DIRECTION 8'h00
`define GPA_RST_FUNC_SEL_A 8'h00
`define GPA_RST_FUNC_SEL_B 8'h00

// pins that carry a peripheral: 0..3 serial, 4..6 i2c
`define GPA_PERIPH_MASK 8'h7F
`define GPA_SERIAL_MASK 8'h0F
`define GPA_I2C_MASK 8'h70

// response codes
`define GPA_RESP_OKAY 2'h0
`define GPA_RESP_SLVERR 2'h2

`endif

// *** shared/gpa_pkg.sv ***
// gpa_pkg.sv: types of the io port
// assumes: gpa_map.svh on the include path
`include "gpa_map.svh"

package gpa_pkg;

  typedef logic [`GPA_PORT_W-1:0] gpa_port_t;
  typedef logic [`GPA_ADDR_W-1:0] gpa_addr_t;
  typedef logic [`GPA_DATA_W-1:0] gpa_data_t;

  typedef enum logic [1:0]
  {
    GPA_RD_IDLE = 2'h0,
    GPA_RD_RESP = 2'h1
  } gpa_rd_state_e;

  typedef enum logic [1:0]
  {
    GPA_WR_IDLE = 2'h0,
    GPA_WR_RESP = 2'h1
  } gpa_wr_state_e;

endpackage

// *** src/gpa_pin_sync.sv ***
// gpa_pin_sync.sv: two flip-flop synchroniser for the port pins
// assumes: pins are asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module gpa_pin_sync
  import gpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire gpa_pkg::gpa_port_t async_i,
  output gpa_pkg::gpa_port_t sync_o
);

  gpa_port_t meta_q;
  gpa_port_t sync_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

// *** src/gpa_pin_ctrl.sv ***
// gpa_pin_ctrl.sv: per-pin output mode decode from the four control bits
// assumes: purely combinational, outputs registered by the caller
`timescale 1ns/1ps
`default_nettype none
`include "gpa_map.svh"

module gpa_pin_ctrl
  import gpa_pkg::*;
(
  input wire gpa_pkg::gpa_port_t latch_i,
  input wire gpa_pkg::gpa_port_t dir_i,
  input wire gpa_pkg::gpa_port_t fsa_i,
  input wire gpa_pkg::gpa_port_t fsb_i,
  input wire gpa_pkg::gpa_port_t periph_out_i,
  output gpa_pkg::gpa_port_t drive_o,
  output gpa_pkg::gpa_port_t level_o,
  output gpa_pkg::gpa_port_t pullup_o,
  output gpa_pkg::gpa_port_t slow_o,
  output gpa_pkg::gpa_port_t invert_o
);

  localparam gpa_port_t PERIPH_PINS = `GPA_PERIPH_MASK;

  // one pin: {drive, level, pullup, slow, invert}
  function automatic logic [4:0] pin_mode(input logic a, input logic b,
    input logic l, input logic d, input logic p);
    logic [4:0] m;
    m = 5'h00;
    case ({a, b, l, d})
      4'b0000: m = 5'b00000;
      4'b0010: m = 5'b00100; // pull-up from latch
      4'b0001: m = 5'b10000;
      4'b0011: m = 5'b11000; // drive latch value
      4'b0100: m = 5'b10010;
      4'b0110: m = 5'b11010; // slow change
      4'b0101: m = 5'b10000;
      4'b0111: m = 5'b00001; // open, inverted read
      4'b1000: m = 5'b10000;
      4'b1010: m = {1'b1, ~p, 3'b001}; // inverted peripheral
      4'b1001: m = {1'b1, p, 3'b000};
      4'b1011: m = 5'b11000;
      4'b1100: m = 5'b10010;
      4'b1110: m = {1'b1, p, 3'b010};
      4'b1101: m = {~p, 4'b0000}; // open drain peripheral
      4'b1111: m = 5'b00000;
      default: m = 5'b00000;
    endcase
    return m;
  endfunction

  always_comb
  begin
    logic [4:0] m;
    m = 5'h00;
    drive_o = 8'h00;
    level_o = 8'h00;
    pullup_o = 8'h00;
    slow_o = 8'h00;
    invert_o = 8'h00;
    for (int i = 0; i < `GPA_PORT_W; i++)
    begin
      // function a only where a peripheral shares the pin
      m = pin_mode(fsa_i[i] & PERIPH_PINS[i], fsb_i[i], latch_i[i],
        dir_i[i], periph_out_i[i]);
      drive_o[i] = m[4];
      level_o[i] = m[3];
      pullup_o[i] = m[2];
      slow_o[i] = m[1];
      invert_o[i] = m[0];
    end
  end

endmodule

`default_nettype wire

// *** dv/gpa_port_assertions.sv ***
// gpa_port_assertions.sv: checker of the io port's bus and pin outputs
// assumes: bound into every gpa_port, sees its ports only
`timescale 1ns/1ps
`default_nettype none

module gpa_port_chk
  import gpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gpa_pkg::gpa_data_t s_axi_rdata,
  input wire gpa_pkg::gpa_port_t pin_i,
  input wire gpa_pkg::gpa_port_t pin_oe_o,
  input wire gpa_pkg::gpa_port_t pullup_en_o,
  input wire gpa_pkg::gpa_port_t slow_change_o,
  input wire logic [3:0] synchronous_serial_channel_in_o,
  input wire logic [2:0] slave_i2c_interface_in_o
);
  logic [2:0] up_q;
  gpa_port_t p1_q, p2_q, p3_q;
  // cycles since reset, pin history
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  always_ff @(posedge ref_clk_i)
  begin
    p1_q <= pin_i;
    p2_q <= p1_q;
    p3_q <= p2_q;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_pins_open: assert property ($fell(rst_i) |->
    pin_oe_o == 8'h00 && pullup_en_o == 8'h00 && slow_change_o == 8'h00)
    else $error("pins not open after reset");
  a_pullup_not_drive: assert property (
    (pullup_en_o & pin_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_slow_needs_drive: assert property (
    (slow_change_o & ~pin_oe_o) == 8'h00)
    else $error("slow change on an undriven pin");
  a_read_answer_time: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_data_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_write_resp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_serial_raw_level: assert property (up_q == 3'h7 |->
    synchronous_serial_channel_in_o == p3_q[3:0])
    else $error("serial input not the pin level");
  a_i2c_raw_level: assert property (up_q == 3'h7 |->
    slave_i2c_interface_in_o == p3_q[6:4])
    else $error("i2c input not the pin level");
endmodule

bind gpa_port gpa_port_chk u_chk (.ref_clk_i, .rst_i, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_i, .pin_oe_o,
  .pullup_en_o, .slow_change_o, .synchronous_serial_channel_in_o,
  .slave_i2c_interface_in_o);
`default_nettype wire

// *** dv/gpa_pin_model.sv ***
// gpa_pin_model.sv: wire level of the eight external pins
// assumes: bench drives the outside driver value and enable
`timescale 1ns/1ps
`default_nettype none

module gpa_pin_model
  import gpa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire gpa_pkg::gpa_port_t drv_i,
  input wire gpa_pkg::gpa_port_t oe_i,
  input wire gpa_pkg::gpa_port_t pu_i,
  input wire gpa_pkg::gpa_port_t ext_i,
  input wire gpa_pkg::gpa_port_t ext_oe_i,
  output var gpa_pkg::gpa_port_t level_o
);
  gpa_port_t flt_q = 8'h5A;
  // floating pins change every cycle
  always @(posedge ref_clk_i)
    flt_q <= ~flt_q;
  always_comb
    level_o = (oe_i & drv_i) | (~oe_i & ext_oe_i & ext_i)
      | (~oe_i & ~ext_oe_i & (pu_i | flt_q));
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// tb_top.sv: self-checking bench of the io port
// assumes: axi4-lite master, pin model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "gpa_map.svh"

module tb_top;
  import gpa_pkg::*;
  localparam gpa_addr_t LAT_A = {`GPA_IDX_OUTPUT_LATCH, 2'b00};
  localparam gpa_addr_t PIN_A = {`GPA_IDX_PIN_INPUT, 2'b00};
  localparam gpa_addr_t DIR_A = {`GPA_IDX_DIRECTION, 2'b00};
  localparam gpa_addr_t FSA_A = {`GPA_IDX_FUNC_SEL_A, 2'b00};
  localparam gpa_addr_t FSB_A = {`GPA_IDX_FUNC_SEL_B, 2'b00};
  gpa_addr_t rw_a [4] = '{LAT_A, DIR_A, FSA_A, FSB_A};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] br, rr, r;
  gpa_addr_t awa = 18'h0, ara = 18'h0;
  gpa_data_t wd = 32'h0, rd, d;
  gpa_port_t pin, po, poe, pu, sl, ext = 8'h00, ext_oe = 8'h00;
  gpa_port_t eoe, eo, epu, esl, einv, ev, pv, lv;
  logic [3:0] sso = 4'h0, ssi, mm;
  logic [3:0] ws = 4'hF;
  logic [2:0] i2o = 3'h0, i2i;
  logic [4:0] e;
  int bad_count = 0, tests_run = 0, cyc = 0;
  always #2 clk = ~clk;

  gpa_port dut (.ref_clk_i(clk), .rst_i(rst), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .pin_i(pin),
    .pin_o(po), .pin_oe_o(poe), .pullup_en_o(pu), .slow_change_o(sl),
    .synchronous_serial_channel_out_i(sso),
    .synchronous_serial_channel_in_o(ssi),
    .slave_i2c_interface_out_i(i2o), .slave_i2c_interface_in_o(i2i));
  gpa_pin_model pins (.ref_clk_i(clk), .drv_i(po), .oe_i(poe), .pu_i(pu),
    .ext_i(ext), .ext_oe_i(ext_oe), .level_o(pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wr_reg(input gpa_addr_t a, input gpa_data_t v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      ta |= awv & awr;
      tw |= wv & wr;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end
    do @(posedge clk); while (!bv);
    bre <= 1'b1;
    @(posedge clk);
    r = br;
    bre <= 1'b0;
  endtask

  task automatic rd_reg(input gpa_addr_t a);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end
    while (!rv);
    rre <= 1'b1;
    @(posedge clk);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask

  task automatic rst_dut();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // oe, level, pull-up, slow, inverted read for {a, b, latch, dir}
  function automatic logic [4:0] mode(input logic [3:0] m, input logic p);
    case (m)
      4'h1, 4'h5, 4'h8: mode = 5'h10;
      4'h2: mode = 5'h04;
      4'h3, 4'hB: mode = 5'h18;
      4'h4, 4'hC: mode = 5'h12;
      4'h6: mode = 5'h1A;
      4'h7: mode = 5'h01;
      4'h9: mode = {1'b1, p, 3'h0};
      4'hA: mode = {1'b1, ~p, 3'h1};
      4'hD: mode = {~p, 4'h0};
      4'hE: mode = {1'b1, p, 3'h2};
      default: mode = 5'h00;
    endcase
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(14042));
    rst_dut();
    for (int k = 0; k < 2; k++)
    begin
      chk(poe, 8'h00);
      chk(pu, 8'h00);
      foreach (rw_a[i])
      begin
        rd_reg(rw_a[i]);
        chk(d, 32'h0);
      end
      ws <= 4'hE;
      wr_reg(LAT_A, 32'hFF);
      chk(r, `GPA_RESP_OKAY);
      ws <= 4'hF;
      rd_reg(LAT_A);
      chk(d, 32'h0);
      for (int n = 0; n < 8; n++)
        foreach (rw_a[i])
        begin
          ev = 8'($urandom);
          wr_reg(rw_a[i], {24'($urandom), ev});
          chk(r, `GPA_RESP_OKAY);
          rd_reg(rw_a[i]);
          chk(r, `GPA_RESP_OKAY);
          chk(d, {24'h0, ev});
        end
      wr_reg(PIN_A, $urandom);
      chk(r, `GPA_RESP_OKAY);
      wr_reg(18'h00010, $urandom);
      chk(r, `GPA_RESP_SLVERR);
      rd_reg(18'h00010);
      chk(r, `GPA_RESP_SLVERR);
      chk(d, 32'h0);
      rst_dut();
    end
    for (int m = 0; m < 16; m++)
    begin
      mm = m[3:0];
      sso <= 4'($urandom);
      i2o <= 3'($urandom);
      ev = 8'($urandom);
      @(posedge clk);
      pv = {1'b0, i2o, sso};
      for (int i = 0; i < 8; i++)
      begin
        e = mode(i == 7 ? {1'b0, mm[2:0]} : mm, pv[i]);
        {eoe[i], eo[i], epu[i], esl[i], einv[i]} = e;
      end
      lv = (eoe & eo) | (~eoe & ev);
      ext <= ev;
      ext_oe <= ~eoe;
      wr_reg(FSA_A, {24'h0, {8{mm[3]}}});
      wr_reg(FSB_A, {24'h0, {8{mm[2]}}});
      wr_reg(LAT_A, {24'h0, {8{mm[1]}}});
      wr_reg(DIR_A, {24'h0, {8{mm[0]}}});
      repeat (4) @(posedge clk);
      chk(poe, eoe);
      chk(po & eoe, eo & eoe);
      chk({pu, sl}, {epu, esl});
      rd_reg(PIN_A);
      chk(r, `GPA_RESP_OKAY);
      chk(d, {24'h0, lv ^ einv});
      chk(ssi, lv[3:0]);
      chk(i2i, lv[6:4]);
    end
    ext_oe <= 8'h00;
    wr_reg(FSB_A, 32'h0);
    wr_reg(DIR_A, 32'h0);
    wr_reg(FSA_A, 32'h0);
    repeat (4) @(posedge clk);
    rd_reg(PIN_A);
    chk(d, 32'h000000FF);
    stop_test();
  end
endmodule
`default_nettype wire
